// ===== system_address_map_boot_remap.sv
`timescale 1ns/100ps
`default_nettype none
`include "system_map_params.svh"

module system_address_map_boot_remap (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic boot_select_low,
	input wire logic boot_select_high,
	input wire logic standby_exit,
	output var system_map_pkg::boot_t boot_mode,
	// Masters: 0 core_data_bus, 1 core system bus, 2 dma_master_one, 3 dma_master_two
	input wire logic [3:0] m_req,
	input wire logic [3:0][31:0] m_addr,
	input wire logic [3:0] m_write,
	input wire logic [3:0][1:0] m_size,
	input wire logic [3:0][31:0] m_wdata,
	output logic [3:0] m_done,
	output logic [3:0] m_err,
	output logic [31:0] m_rdata,
	output logic [6:0] s_sel,
	output logic [31:0] s_addr,
	output logic s_write,
	output logic [1:0] s_size,
	output logic [3:0] s_strb,
	output logic [31:0] s_wdata,
	input wire logic [6:0] s_ready,
	input wire logic [6:0] s_err,
	input wire logic [6:0][31:0] s_rdata,
	input wire logic ibus_req,
	input wire logic [31:0] ibus_addr,
	output logic ibus_done,
	output logic ibus_err,
	output logic [31:0] ibus_rdata,
	output logic fi_req,
	output logic [31:0] fi_addr,
	input wire logic fi_ready,
	input wire logic [31:0] fi_rdata
);
	system_map_pkg::state_t state;
	system_map_pkg::route_t next_route, cur_route, ib_route;
	logic grant_valid, cur_write, cur_wbit, sel_ready, sel_err, next_apb, misalign;
	logic [1:0] grant_idx, cur_master, cur_size, cur_lo;
	logic [31:0] sel_rdata, bb_word;
	logic [4:0] bb_pos;
	// ---------------------------------------------
	// Address decoding
	// ---------------------------------------------
	function automatic system_map_pkg::boot_t boot_from_pins(input logic low, input logic high);
		if (!low) begin
			return system_map_pkg::BOOT_FLASH;
		end else if (!high) begin
			return system_map_pkg::BOOT_SYSMEM;
		end
		return system_map_pkg::BOOT_SRAM;
	endfunction
	function automatic system_map_pkg::route_t native_route(input logic [31:0] a);
		system_map_pkg::route_t r;
		r = '0;
		r.addr = a;
		r.ok = 1'b1;
		r.slave = system_map_pkg::SLV_FLASH;
		if ((a >= `FLASH_BASE && a < `FLASH_BASE + `FLASH_SIZE) ||
				(a >= `SYSMEM_BASE && a < `OPTION_BASE + `OPTION_SIZE)) begin
			r.slave = system_map_pkg::SLV_FLASH;
		end else if (a >= `SRAM_BASE && a < `SRAM_BASE + `SRAM_SIZE) begin
			r.slave = system_map_pkg::SLV_SRAM;
		end else if (a >= `PER_BASE && a < `APB2_BASE) begin
			r.slave = system_map_pkg::SLV_APB1;
		end else if (a >= `APB2_BASE && a < `AHB_PER_BASE) begin
			r.slave = system_map_pkg::SLV_APB2;
		end else if (a >= `AHB_PER_BASE && a < `PER_LIMIT) begin
			r.slave = system_map_pkg::SLV_AHB;
		end else if (a >= `EMC_BASE && a < `PPB_BASE) begin
			r.slave = system_map_pkg::SLV_EMC;
		end else if (a >= `PPB_BASE) begin
			r.slave = system_map_pkg::SLV_PPB;
		end else begin
			r.ok = 1'b0;
		end
		return r;
	endfunction
	function automatic system_map_pkg::route_t decode_addr(input logic [31:0] a,
			input system_map_pkg::boot_t bm);
		system_map_pkg::route_t r;
		logic [31:0] na;
		logic bad, bb;
		na = a;
		bad = 1'b0;
		bb = 1'b0;
		if (a < `FLASH_BASE) begin
			case (bm)
				system_map_pkg::BOOT_FLASH: begin
					na = `FLASH_BASE + a;
					bad = (a >= `FLASH_SIZE);
				end
				system_map_pkg::BOOT_SYSMEM: begin
					na = `SYSMEM_BASE + a;
					bad = (a >= `SYSMEM_SIZE);
				end
				default: begin
					bad = 1'b1;
				end
			endcase
		end else if (a >= `SRAM_BB_ALIAS && a < `SRAM_BB_ALIAS + `BB_ALIAS_SIZE) begin
			na = `SRAM_BASE + {12'h000, a[24:5]};
			bb = 1'b1;
		end else if (a >= `PER_BB_ALIAS && a < `PER_BB_ALIAS + `BB_ALIAS_SIZE) begin
			na = `PER_BASE + {12'h000, a[24:5]};
			bb = 1'b1;
		end
		r = native_route(na);
		r.ok = r.ok && !bad;
		r.bitband = bb;
		r.bitnum = a[4:2];
		return r;
	endfunction

	// ---------------------------------------------
	// Lane handling
	// ---------------------------------------------
	function automatic logic [3:0] lane_strb(input logic [1:0] size, input logic [1:0] lo);
		case (size)
			system_map_pkg::SZ_BYTE: return 4'h1 << lo;
			system_map_pkg::SZ_HALF: return lo[1] ? 4'hc : 4'h3;
			default: return 4'hf;
		endcase
	endfunction
	// Narrow writes go out on every lane; APB registers see the copies
	function automatic logic [31:0] replicate(input logic [1:0] size, input logic [31:0] d);
		case (size)
			system_map_pkg::SZ_BYTE: return {4{d[7:0]}};
			system_map_pkg::SZ_HALF: return {2{d[15:0]}};
			default: return d;
		endcase
	endfunction
	function automatic logic [31:0] extract(input logic [1:0] size, input logic [1:0] lo,
			input logic [31:0] w);
		case (size)
			system_map_pkg::SZ_BYTE: return {24'h00_0000, w[{lo, 3'h0} +: 8]};
			system_map_pkg::SZ_HALF: return lo[1] ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
			default: return w;
		endcase
	endfunction
	function automatic logic misaligned(input logic [1:0] size, input logic [1:0] lo);
		case (size)
			system_map_pkg::SZ_BYTE: return 1'b0;
			system_map_pkg::SZ_HALF: return lo[0];
			system_map_pkg::SZ_WORD: return lo != 2'h0;
			default: return 1'b1;
		endcase
	endfunction
	always_comb begin
		next_route = decode_addr(m_addr[grant_idx], boot_mode);
		ib_route = decode_addr(ibus_addr, boot_mode);
		next_apb = next_route.slave == system_map_pkg::SLV_APB1 ||
			next_route.slave == system_map_pkg::SLV_APB2;
		misalign = misaligned(m_size[grant_idx], m_addr[grant_idx][1:0]);
		sel_rdata = s_rdata[cur_route.slave];
		sel_ready = s_ready[cur_route.slave];
		sel_err = s_err[cur_route.slave];
		bb_pos = {cur_route.addr[1:0], cur_route.bitnum};
		bb_word = sel_rdata;
		bb_word[bb_pos] = cur_wbit;
	end
	// ---------------------------------------------
	// Boot mode latch
	// ---------------------------------------------
	// Pins are followed while reset or standby_exit is high, frozen otherwise
	always_ff @(posedge ref_clk) begin
		if (sys_rst || standby_exit) begin
			boot_mode <= boot_from_pins(boot_select_low, boot_select_high);
		end
	end
	// ---------------------------------------------
	// Matrix access sequencer
	// ---------------------------------------------
	master_arbiter arb (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.req(m_req),
		.advance(state == system_map_pkg::ST_RESP),
		.served(cur_master),
		.grant_valid(grant_valid),
		.grant_idx(grant_idx)
	);
	// Sequencer stays busy across both bit-band halves, so nobody slips in
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= system_map_pkg::ST_IDLE;
			s_sel <= 7'h00;
			s_addr <= 32'h0000_0000;
			s_write <= 1'b0;
			s_size <= system_map_pkg::SZ_WORD;
			s_strb <= 4'h0;
			s_wdata <= 32'h0000_0000;
			m_done <= 4'h0;
			m_err <= 4'h0;
			m_rdata <= 32'h0000_0000;
			cur_master <= 2'h0;
			cur_route <= '0;
			cur_size <= 2'h0;
			cur_lo <= 2'h0;
			cur_write <= 1'b0;
			cur_wbit <= 1'b0;
		end else begin
			case (state)
				system_map_pkg::ST_IDLE: begin
					if (grant_valid) begin
						cur_master <= grant_idx;
						cur_route <= next_route;
						cur_size <= m_size[grant_idx];
						cur_lo <= m_addr[grant_idx][1:0];
						cur_write <= m_write[grant_idx];
						cur_wbit <= m_wdata[grant_idx][0];
						if (!next_route.ok || (misalign && !next_route.bitband)) begin
							m_err[grant_idx] <= 1'b1;
							m_done[grant_idx] <= 1'b1;
							state <= system_map_pkg::ST_RESP;
						end else begin
							s_sel <= 7'h01 << next_route.slave;
							s_write <= m_write[grant_idx] && !next_route.bitband;
							if (next_apb) begin
								s_size <= system_map_pkg::SZ_WORD;
								s_addr <= {next_route.addr[31:2], 2'h0};
								s_strb <= 4'hf;
							end else if (next_route.bitband) begin
								s_size <= system_map_pkg::SZ_BYTE;
								s_addr <= next_route.addr;
								s_strb <= lane_strb(system_map_pkg::SZ_BYTE, next_route.addr[1:0]);
							end else begin
								s_size <= m_size[grant_idx];
								s_addr <= next_route.addr;
								s_strb <= lane_strb(m_size[grant_idx], next_route.addr[1:0]);
							end
							s_wdata <= replicate(m_size[grant_idx], m_wdata[grant_idx]);
							state <= system_map_pkg::ST_ACCESS;
						end
					end
				end
				system_map_pkg::ST_ACCESS: begin
					if (sel_ready) begin
						if (sel_err) begin
							s_sel <= 7'h00;
							s_write <= 1'b0;
							m_err[cur_master] <= 1'b1;
							m_done[cur_master] <= 1'b1;
							state <= system_map_pkg::ST_RESP;
						end else if (cur_route.bitband && cur_write) begin
							s_write <= 1'b1;
							s_wdata <= bb_word;
							state <= system_map_pkg::ST_BB_WRITE;
						end else begin
							s_sel <= 7'h00;
							s_write <= 1'b0;
							if (cur_route.bitband) begin
								m_rdata <= {31'h0, sel_rdata[bb_pos]};
							end else begin
								m_rdata <= extract(cur_size, cur_lo, sel_rdata);
							end
							m_done[cur_master] <= 1'b1;
							state <= system_map_pkg::ST_RESP;
						end
					end
				end
				system_map_pkg::ST_BB_WRITE: begin
					if (sel_ready) begin
						s_sel <= 7'h00;
						s_write <= 1'b0;
						m_err[cur_master] <= sel_err;
						m_done[cur_master] <= 1'b1;
						state <= system_map_pkg::ST_RESP;
					end
				end
				system_map_pkg::ST_RESP: begin
					m_done <= 4'h0;
					m_err <= 4'h0;
					state <= system_map_pkg::ST_IDLE;
				end
				default: state <= system_map_pkg::ST_IDLE;
			endcase
		end
	end
	// ---------------------------------------------
	// Instruction path
	// ---------------------------------------------
	// Only flash-backed space is fetchable; SRAM code must run via the matrix
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fi_req <= 1'b0;
			fi_addr <= 32'h0000_0000;
			ibus_done <= 1'b0;
			ibus_err <= 1'b0;
			ibus_rdata <= 32'h0000_0000;
		end else if (fi_req) begin
			if (fi_ready) begin
				fi_req <= 1'b0;
				ibus_done <= 1'b1;
				ibus_rdata <= fi_rdata;
			end
		end else if (ibus_done) begin
			ibus_done <= 1'b0;
			ibus_err <= 1'b0;
		end else if (ibus_req) begin
			if (ib_route.ok && !ib_route.bitband && ib_route.slave == system_map_pkg::SLV_FLASH) begin
				fi_req <= 1'b1;
				fi_addr <= ib_route.addr;
			end else begin
				ibus_done <= 1'b1;
				ibus_err <= 1'b1;
			end
		end
	end
	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	a_flash_zero_alias: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == system_map_pkg::ST_IDLE && grant_valid && boot_mode == system_map_pkg::BOOT_FLASH
		&& m_addr[grant_idx] < `FLASH_SIZE && !misalign) |=>
		(s_sel == 7'h01 && s_addr == `FLASH_BASE + $past(m_addr[grant_idx])))
		else $error("flash alias not routed to native flash");
	a_sysmem_zero_alias: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == system_map_pkg::ST_IDLE && grant_valid && boot_mode == system_map_pkg::BOOT_SYSMEM
		&& m_addr[grant_idx] < `SYSMEM_SIZE && !misalign) |=>
		(s_sel == 7'h01 && s_addr == `SYSMEM_BASE + $past(m_addr[grant_idx])))
		else $error("system memory alias wrong");
	a_sram_no_alias: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == system_map_pkg::ST_IDLE && grant_valid && boot_mode == system_map_pkg::BOOT_SRAM
		&& m_addr[grant_idx] < `FLASH_BASE) |=>
		(state == system_map_pkg::ST_RESP && s_sel == 7'h00 && m_err[cur_master]))
		else $error("address zero answered in SRAM boot");
	a_reset_boot_latch: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$fell(sys_rst) |-> boot_mode == boot_from_pins($past(boot_select_low), $past(boot_select_high)))
		else $error("boot mode not taken at reset");
	a_standby_relatch: assert property (@(posedge ref_clk) disable iff (sys_rst)
		standby_exit |=> boot_mode == boot_from_pins($past(boot_select_low), $past(boot_select_high)))
		else $error("boot mode not relatched on standby exit");
	a_sram_byte_lane: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == system_map_pkg::ST_ACCESS && s_sel[1] && s_size == system_map_pkg::SZ_BYTE)
		|-> $countones(s_strb) == 1)
		else $error("SRAM byte access drives wrong strobes");
	a_bitband_rmw: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == system_map_pkg::ST_ACCESS && cur_route.bitband && cur_write && sel_ready
		&& !sel_err) |=> (state == system_map_pkg::ST_BB_WRITE && s_write && s_sel == $past(s_sel)
		&& s_wdata[bb_pos] == cur_wbit))
		else $error("bit-band write did not modify one bit");
	a_bitband_target: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == system_map_pkg::ST_IDLE && grant_valid && next_route.bitband && next_route.ok)
		|=> s_addr[19:2] == $past(m_addr[grant_idx][24:7]) && !s_write)
		else $error("bit-band target address wrong");
	a_apb_widened: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == system_map_pkg::ST_ACCESS && (s_sel[3] || s_sel[4])) |->
		(s_size == system_map_pkg::SZ_WORD && s_addr[1:0] == 2'h0 && s_strb == 4'hf))
		else $error("APB access not widened to a word");
	a_unmapped_error: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(state == system_map_pkg::ST_IDLE && grant_valid && !next_route.ok) |=>
		m_done[cur_master] && m_err[cur_master] ##1 (m_done == 4'h0 && state == system_map_pkg::ST_IDLE))
		else $error("unmapped access not errored in one cycle");
	a_ifetch_direct: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!fi_req && !ibus_done && ibus_req && ib_route.ok && !ib_route.bitband
		&& ib_route.slave == system_map_pkg::SLV_FLASH) |=> (fi_req && fi_addr == $past(ib_route.addr)))
		else $error("instruction fetch not sent to flash port");
endmodule

`default_nettype wire

// ===== system_map_params.svh
// Contract
// - Boot pin low at 0 aliases main flash at zero; flash also stays at native base.
// - Pins high 0, low 1 alias system memory at zero; also reachable natively.
// - Both pins 1 boot from SRAM; SRAM only at its native base, no alias.
// - Boot pins are sampled at reset to fix the boot mode and alias.
// - Boot pins latched again on standby exit; outside holds them during standby.
// - SRAM takes byte, halfword and word accesses, each correctly sized.
// - Word write to bit-band alias is an atomic read-modify-write using bit 0.
// - Alias address equals alias base plus byte offset times 32 plus bit times 4.
// - Bit-band covers SRAM and peripheral regions for single-bit reads and writes.
// - Bridges turn byte or halfword accesses to APB registers into 32-bit accesses.
// - Bridges connect AHB synchronously to APB buses with differing rates.
// - Interconnect arbitrates four masters onto SRAM, flash, external memory and bridges.
// - Contention between data bus and DMA resolved; AHB peripherals reachable by DMA.
// - Reset vector fetched over instruction bus wired directly to flash instruction port.
// - Decoder treats the full 4GB space as one map.
// - Flash decode gives 512KB main, 2KB system memory and 16-byte option area.
`ifndef SYSTEM_MAP_PARAMS_SVH
`define SYSTEM_MAP_PARAMS_SVH

`define FLASH_BASE 32'h0800_0000
`define FLASH_SIZE 32'h0008_0000
`define SYSMEM_BASE 32'h1fff_f000
`define SYSMEM_SIZE 32'h0000_0800
`define OPTION_BASE 32'h1fff_f800
`define OPTION_SIZE 32'h0000_0010
`define SRAM_BASE 32'h2000_0000
`define SRAM_SIZE 32'h0001_0000
`define SRAM_BB_ALIAS 32'h2200_0000
`define PER_BASE 32'h4000_0000
`define APB2_BASE 32'h4001_0000
`define AHB_PER_BASE 32'h4001_8000
`define PER_BB_ALIAS 32'h4200_0000
`define BB_ALIAS_SIZE 32'h0200_0000
`define PER_LIMIT 32'h6000_0000
`define EMC_BASE 32'h6000_0000
`define PPB_BASE 32'he000_0000

`endif

// ===== system_map_pkg.sv
package system_map_pkg;
	typedef enum logic [1:0] {
		BOOT_FLASH = 2'h0,
		BOOT_SYSMEM = 2'h1,
		BOOT_SRAM = 2'h2
	} boot_t;
	typedef enum logic [2:0] {
		SLV_FLASH = 3'h0,
		SLV_SRAM = 3'h1,
		SLV_EMC = 3'h2,
		SLV_APB1 = 3'h3,
		SLV_APB2 = 3'h4,
		SLV_AHB = 3'h5,
		SLV_PPB = 3'h6
	} slave_t;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} size_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ACCESS = 2'h1,
		ST_BB_WRITE = 2'h2,
		ST_RESP = 2'h3
	} state_t;
	typedef struct packed {
		logic ok;
		logic bitband;
		logic [2:0] bitnum;
		slave_t slave;
		logic [31:0] addr;
	} route_t;
endpackage

// ===== master_arbiter.sv
`timescale 1ns/100ps
`default_nettype none

module master_arbiter (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [3:0] req,
	input wire logic advance,
	input wire logic [1:0] served,
	output logic grant_valid,
	output logic [1:0] grant_idx
);
	logic [1:0] last;
	logic [1:0] cand;

	// Round robin: the master just served drops to lowest priority
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			last <= 2'h3;
		end else if (advance) begin
			last <= served;
		end
	end

	always_comb begin
		grant_valid = 1'b0;
		grant_idx = 2'h0;
		cand = 2'h0;
		for (int i = 4; i >= 1; i--) begin
			cand = last + i[1:0];
			if (req[cand]) begin
				grant_valid = 1'b1;
				grant_idx = cand;
			end
		end
	end
endmodule

`default_nettype wire

// ===== slave_port_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Slaves and flash fetch port
// ----------------------------------------
module slave_port_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic [6:0] s_sel,
	input wire logic [31:0] s_addr,
	input wire logic s_write,
	input wire logic [3:0] s_strb,
	input wire logic [31:0] s_wdata,
	output logic [6:0] s_ready,
	output logic [6:0] s_err,
	output logic [6:0][31:0] s_rdata,
	input wire logic fi_req,
	input wire logic [31:0] fi_addr,
	output logic fi_ready,
	output logic [31:0] fi_rdata
);
	logic [31:0] mem [1024];
	logic [2:0] cnt;
	logic [2:0] lat;
	logic junk;
	assign lat = slow ? 3'h3 : 3'h0;
	// Regions told apart by address bits 30:27 only (EMC and PPB share, as do APB1, APB2 and AHB); only low offsets are stored
	function automatic logic [9:0] key(input logic [31:0] a);
		return {a[30:27], a[7:2]};
	endfunction
	always_ff @(posedge ref_clk) begin
		junk <= sys_rst ? 1'b0 : ~junk;
		if ((s_sel != 7'h00 || fi_req) && s_ready == 7'h00 && !fi_ready)
			cnt <= cnt + 3'h1;
		else
			cnt <= 3'h0;
		for (int b = 0; b < 4; b++)
			if (s_ready != 7'h00 && s_write && s_strb[b])
				mem[key(s_addr)][b*8 +: 8] <= s_wdata[b*8 +: 8];
	end
	// Unselected lines toggle so stale data never looks valid
	always_comb begin
		for (int i = 0; i < 7; i++)
			s_rdata[i] = s_sel[i] ? mem[key(s_addr)] : {32{junk}};
		s_ready = (cnt >= lat) ? s_sel : 7'h00;
		s_err = (s_addr[15:0] == 16'hbad0) ? s_ready : 7'h00;
		fi_ready = fi_req && cnt >= lat;
		fi_rdata = fi_ready ? mem[key(fi_addr)] : {32{~junk}};
	end
endmodule

`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic ref_clk = 1'b0;
	logic sys_rst, boot_select_low, boot_select_high, standby_exit, slow;
	system_map_pkg::boot_t boot_mode;
	logic [3:0] m_req, m_write, m_done, m_err, s_strb, cap_strb;
	logic [3:0][31:0] m_addr, m_wdata;
	logic [3:0][1:0] m_size;
	logic [31:0] m_rdata, s_addr, s_wdata, ibus_addr, ibus_rdata, fi_addr, fi_rdata, cap_addr;
	logic [6:0] s_sel, s_ready, s_err, cap_sel;
	logic s_write, ibus_req, ibus_done, ibus_err, fi_req, fi_ready;
	logic [1:0] s_size, cap_size;
	logic [6:0][31:0] s_rdata;
	int error_cnt = 0;
	int n_compared = 0;

	always #20 ref_clk = ~ref_clk;

	system_address_map_boot_remap dut (.ref_clk, .sys_rst, .boot_select_low,
		.boot_select_high, .standby_exit, .boot_mode, .m_req, .m_addr, .m_write,
		.m_size, .m_wdata, .m_done, .m_err, .m_rdata, .s_sel, .s_addr, .s_write,
		.s_size, .s_strb, .s_wdata, .s_ready, .s_err, .s_rdata, .ibus_req,
		.ibus_addr, .ibus_done, .ibus_err, .ibus_rdata, .fi_req, .fi_addr,
		.fi_ready, .fi_rdata);
	slave_port_model slaves (.ref_clk, .sys_rst, .slow, .s_sel, .s_addr, .s_write,
		.s_strb, .s_wdata, .s_ready, .s_err, .s_rdata, .fi_req, .fi_addr,
		.fi_ready, .fi_rdata);

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (e !== g) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic timeout(input string what);
		error_cnt++;
		$display("FAIL %s expected done seen timeout", what);
		end_of_test();
	endtask

	task automatic do_reset(input logic hi, input logic lo);
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		boot_select_high <= hi;
		boot_select_low <= lo;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Master transfer, held until its done pulse
	// ----------------------------------------
	task automatic access(input int m, input logic [31:0] a, input logic wr,
			input logic [1:0] sz, input logic [31:0] wd, input logic ee,
			output logic [31:0] data);
		int n;
		@(posedge ref_clk);
		m_req[m] <= 1'b1;
		m_addr[m] <= a;
		m_write[m] <= wr;
		m_size[m] <= sz;
		m_wdata[m] <= wd;
		cap_sel = 7'h00;
		for (n = 0; n < 40 && m_done[m] !== 1'b1; n++) begin
			@(negedge ref_clk);
			if (s_sel != 7'h00 && cap_sel == 7'h00) begin
				cap_sel = s_sel;
				cap_size = s_size;
				cap_strb = s_strb;
				cap_addr = s_addr;
			end
		end
		if (n == 40)
			timeout("m_done");
		check("m_err", ee, m_err[m]);
		data = m_rdata;
		@(posedge ref_clk);
		m_req[m] <= 1'b0;
	endtask

	task automatic wr32(input int m, input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		access(m, a, 1'b1, system_map_pkg::SZ_WORD, d, 1'b0, x);
	endtask

	task automatic rd32(input int m, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] x;
		access(m, a, 1'b0, system_map_pkg::SZ_WORD, 32'h0, 1'b0, x);
		check("read data", e, x);
	endtask

	task automatic bad(input int m, input logic [31:0] a);
		logic [31:0] x;
		access(m, a, 1'b0, system_map_pkg::SZ_WORD, 32'h0, 1'b1, x);
	endtask

	task automatic fetch(input logic [31:0] a, input logic ee, input logic [31:0] e);
		int n;
		@(posedge ref_clk);
		ibus_req <= 1'b1;
		ibus_addr <= a;
		for (n = 0; n < 40 && ibus_done !== 1'b1; n++)
			@(negedge ref_clk);
		if (n == 40)
			timeout("ibus_done");
		check("ibus_err", ee, ibus_err);
		if (!ee)
			check("ibus_rdata", e, ibus_rdata);
		@(posedge ref_clk);
		ibus_req <= 1'b0;
	endtask

	function automatic logic [31:0] bb(input logic [31:0] base, input int off, input int b);
		return base + off * 32 + b * 4;
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_boot_flash();
		do_reset(1'b1, 1'b0);
		check("boot_mode", system_map_pkg::BOOT_FLASH, boot_mode);
		wr32(0, 32'h0800_0000, 32'h2000_1000);
		wr32(1, 32'h0800_0010, 32'hcafe_0010);
		rd32(2, 32'h0000_0010, 32'hcafe_0010);
		rd32(3, 32'h0800_0010, 32'hcafe_0010);
		fetch(32'h0000_0000, 1'b0, 32'h2000_1000);
		bad(0, 32'h0008_0000);
	endtask

	task automatic t_boot_sysmem();
		@(posedge ref_clk);
		boot_select_low <= 1'b1;
		boot_select_high <= 1'b0;
		@(posedge ref_clk);
		standby_exit <= 1'b1;
		@(posedge ref_clk);
		standby_exit <= 1'b0;
		@(posedge ref_clk);
		check("boot_mode", system_map_pkg::BOOT_SYSMEM, boot_mode);
		wr32(1, 32'h1fff_f004, 32'h5eed_0004);
		rd32(0, 32'h0000_0004, 32'h5eed_0004);
		rd32(2, 32'h1fff_f004, 32'h5eed_0004);
		bad(3, 32'h0000_0800);
		// Pins moving while running must not relatch
		boot_select_high <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check("boot_mode", system_map_pkg::BOOT_SYSMEM, boot_mode);
	endtask

	task automatic t_boot_sram();
		do_reset(1'b1, 1'b1);
		check("boot_mode", system_map_pkg::BOOT_SRAM, boot_mode);
		wr32(2, 32'h2000_0040, 32'h1234_5678);
		rd32(3, 32'h2000_0040, 32'h1234_5678);
		bad(0, 32'h0000_0040);
		fetch(32'h0000_0000, 1'b1, 32'h0);
	endtask

	task automatic t_sizes();
		logic [31:0] x;
		wr32(0, 32'h2000_0000, 32'h1122_3344);
		access(1, 32'h2000_0001, 1'b1, system_map_pkg::SZ_BYTE, 32'hab, 1'b0, x);
		check("byte strobe", 4'h2, cap_strb);
		access(2, 32'h2000_0002, 1'b1, system_map_pkg::SZ_HALF, 32'h5566, 1'b0, x);
		check("half strobe", 4'hc, cap_strb);
		rd32(3, 32'h2000_0000, 32'h5566_ab44);
		access(0, 32'h2000_0001, 1'b0, system_map_pkg::SZ_BYTE, 32'h0, 1'b0, x);
		check("byte read", 32'hab, x);
		access(1, 32'h2000_0002, 1'b0, system_map_pkg::SZ_HALF, 32'h0, 1'b0, x);
		check("half read", 32'h5566, x);
		access(2, 32'h2000_0001, 1'b0, system_map_pkg::SZ_HALF, 32'h0, 1'b1, x);
		access(3, 32'h2000_0000, 1'b0, 2'h3, 32'h0, 1'b1, x);
	endtask

	task automatic t_bitband();
		logic [31:0] x;
		wr32(0, 32'h2000_0004, 32'h0000_0004);
		wr32(1, bb(32'h2200_0000, 5, 1), 32'h0000_0001);
		rd32(2, 32'h2000_0004, 32'h0000_0204);
		wr32(3, bb(32'h2200_0000, 4, 2), 32'hffff_fffe);
		rd32(0, 32'h2000_0004, 32'h0000_0200);
		access(1, bb(32'h2200_0000, 5, 1), 1'b0, system_map_pkg::SZ_WORD, 0, 1'b0, x);
		check("sram bit read", 32'h1, x);
		wr32(2, 32'h4000_0008, 32'h0);
		wr32(3, bb(32'h4200_0000, 8, 5), 32'h0000_0001);
		rd32(0, 32'h4000_0008, 32'h0000_0020);
		access(1, bb(32'h4200_0000, 8, 5), 1'b0, system_map_pkg::SZ_WORD, 0, 1'b0, x);
		check("periph bit read", 32'h1, x);
	endtask

	task automatic t_apb();
		logic [31:0] x;
		access(0, 32'h4001_0002, 1'b1, system_map_pkg::SZ_BYTE, 32'h7e, 1'b0, x);
		check("apb select", 7'h10, cap_sel);
		check("apb size", system_map_pkg::SZ_WORD, cap_size);
		check("apb strobe", 4'hf, cap_strb);
		check("apb addr", 32'h4001_0000, cap_addr);
		rd32(1, 32'h4001_0000, 32'h7e7e_7e7e);
		access(2, 32'h4000_0006, 1'b0, system_map_pkg::SZ_HALF, 32'h0, 1'b0, x);
		check("apb half size", system_map_pkg::SZ_WORD, cap_size);
		check("apb half addr", 32'h4000_0004, cap_addr);
	endtask

	task automatic t_route();
		logic [31:0] x;
		logic [31:0] adr [13] = '{32'h0800_0100, 32'h0807_fffc, 32'h0808_0000,
			32'h1fff_f7fc, 32'h1fff_f80c, 32'h1fff_f810, 32'h2000_0100, 32'h2001_0000,
			32'h6000_0000, 32'h4000_0400, 32'h4001_0400, 32'h4002_0000, 32'he000_e000};
		logic [6:0] sel [13] = '{7'h01, 7'h01, 7'h00, 7'h01, 7'h01, 7'h00, 7'h02,
			7'h00, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
		for (int i = 0; i < 13; i++) begin
			access(i % 4, adr[i], 1'b0, system_map_pkg::SZ_WORD, 0, sel[i] == 7'h00, x);
			if (sel[i] != 7'h00)
				check("slave select", sel[i], cap_sel);
		end
		bad(1, 32'h6000_bad0);
	endtask

	task automatic t_contention();
		slow <= 1'b1;
		wr32(0, 32'h2000_0080, 32'haaaa_0001);
		wr32(2, 32'h2000_0084, 32'hbbbb_0002);
		wr32(3, 32'h4001_8010, 32'hcccc_0003);
		fork
			rd32(0, 32'h2000_0084, 32'hbbbb_0002);
			rd32(2, 32'h2000_0080, 32'haaaa_0001);
			rd32(3, 32'h4001_8010, 32'hcccc_0003);
		join
		slow <= 1'b0;
	endtask

	initial begin
		sys_rst = 1'b1;
		boot_select_low = 1'b0;
		boot_select_high = 1'b0;
		standby_exit = 1'b0;
		slow = 1'b0;
		m_req = 4'h0;
		m_addr = '0;
		m_write = 4'h0;
		m_size = '0;
		m_wdata = '0;
		ibus_req = 1'b0;
		ibus_addr = 32'h0;
		t_boot_flash();
		t_boot_sysmem();
		t_boot_sram();
		t_sizes();
		t_bitband();
		t_apb();
		t_route();
		t_contention();
		end_of_test();
	end
endmodule

`default_nettype wire
